// ### design/mtec_pkg.sv
package mtec_pkg;

   // ---------------------------------------------------------------
   // Register map (word aligned byte addresses)
   // ---------------------------------------------------------------
   localparam logic [3:0] MTEC_OFS_CTRL = 4'h0;
   localparam logic [3:0] MTEC_OFS_SPEED = 4'h4;
   localparam logic [3:0] MTEC_OFS_COUNT = 4'h8;
   localparam logic [3:0] MTEC_OFS_RELA = 4'hC;
   localparam logic [3:0] MTEC_OFS_RELB = 4'h0;
   localparam logic [1:0] MTEC_IDX_HI = 2'h1;

   // ---------------------------------------------------------------
   // Control register fields
   // ---------------------------------------------------------------
   localparam int MTEC_BIT_RUN = 0;
   localparam int MTEC_BIT_MODE_LO = 1;
   localparam int MTEC_BIT_MODE_HI = 3;
   localparam int MTEC_BIT_PNDA = 4;
   localparam int MTEC_BIT_ENA = 5;
   localparam int MTEC_BIT_PNDB = 6;
   localparam int MTEC_BIT_ENB = 7;
   localparam int MTEC_BIT_HS = 0;
   localparam logic [7:0] MTEC_CTRL_RST = 8'h00;
   localparam logic [15:0] MTEC_WORD_RST = 16'h0000;

   // ---------------------------------------------------------------
   // Mode encodings {hi,mid,lo}
   // ---------------------------------------------------------------
   localparam logic [2:0] MTEC_M_EVT_POS = 3'h0;
   localparam logic [2:0] MTEC_M_EVT_NEG = 3'h1;
   localparam logic [2:0] MTEC_M_PWM_NT = 3'h4;
   localparam logic [2:0] MTEC_M_PWM_TG = 3'h5;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int MTEC_CLK_MHZ = 100;
   localparam int MTEC_TC_NS = 500;
   localparam int MTEC_MCLK_NS = 50;
   localparam int MTEC_TC_CYC = (MTEC_TC_NS * MTEC_CLK_MHZ) / 1000;
   localparam int MTEC_MCLK_CYC = (MTEC_MCLK_NS * MTEC_CLK_MHZ) / 1000;
   localparam logic [7:0] MTEC_TC_DIV = 8'(MTEC_TC_CYC - 1);
   localparam logic [7:0] MTEC_MCLK_DIV = 8'(MTEC_MCLK_CYC - 1);

   typedef enum logic [0:0] {MTEC_BUS_IDLE, MTEC_BUS_ACK} mtec_bus_t;

   typedef struct packed {
      logic [3:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } mtec_avreq_t;

   typedef struct packed {
      logic [31:0] readdata;
      logic waitrequest;
   } mtec_avrsp_t;

   typedef struct packed {
      logic pin_a;
      logic pin_b;
   } mtec_pins_t;

endpackage

// ### design/mtec_sync.sv
`timescale 1ns/1ns
`default_nettype none
// Three-stage synchroniser; stage 1 feeds only stage 2
module mtec_sync (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Data
   input wire logic din,
   output logic dout,
   output logic rise,
   output logic fall
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic st;
   } mtec_sync_st_t;

   mtec_sync_st_t q, d;

   always_comb begin
      d = q;
      d.s1 = din;
      d.s2 = q.s1;
      d.s3 = q.s2;
      // Change counts once stages 2 and 3 agree
      if (q.s2 == q.s3) begin
         d.st = q.s3;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign dout = q.st;
   assign rise = d.st & ~q.st;
   assign fall = ~d.st & q.st;
endmodule
`default_nettype wire

// ### design/mtec_tick.sv
`timescale 1ns/1ns
`default_nettype none
// Tick generator for instruction-cycle or fast clock rate
module mtec_tick (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Control
   input wire logic fast,
   output logic tick
);
   import mtec_pkg::*;

   typedef struct packed {
      logic [7:0] cnt;
   } mtec_tick_st_t;

   mtec_tick_st_t q, d;
   logic [7:0] lim;

   always_comb begin
      d = q;
      lim = fast ? MTEC_MCLK_DIV : MTEC_TC_DIV;
      if (q.cnt >= lim) begin
         d.cnt = 8'h00;
      end else begin
         d.cnt = q.cnt + 8'h01;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign tick = (q.cnt >= lim);
endmodule
`default_nettype wire

// ### design/mtec_timer.sv
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Counter and two companions are 16 bits
// - PWM underflow reloads alternately from companions
// - First reload from A, then B, A...
// - High-speed bit selects fast clock; reset clears
// - Event mode counts synchronised pin A edges
// - Mode 000 rising, 001 falling pin A
// - Event underflow sets pending A
// - Event mode pin B rise sets pending B
// - Event mode never drives pin A output
// - Capture mode counter runs without stopping
// - Capture copies count into companion A/B
// - Capture edge polarities decoded from mode
// - Capture triggers set pending A and B
// - Capture underflow sets run bit as pending
// - Run bit starts/stops PWM and event modes
// - Enables gate their interrupt requests
// - PWM toggle/no-toggle modes; irq per reload
// - Capture registers readable without disturbing count
// - Control register takes any write with byte 0 enabled
module mtec_timer (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Avalon-MM slave
   input wire mtec_pkg::mtec_avreq_t av_req,
   output mtec_pkg::mtec_avrsp_t av_rsp,
   // Pins
   input wire mtec_pkg::mtec_pins_t pins_in,
   output logic event_or_capture_pin_a_out,
   output logic event_or_capture_pin_a_oe_n,
   // Interrupt requests
   output logic irq_a,
   output logic irq_b
);
   import mtec_pkg::*;

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      mtec_bus_t bus;
      logic waitreq;
      logic [31:0] rdata;
      logic [7:0] ctrl;
      logic high_speed_select;
      logic [15:0] count;
      logic [15:0] reload_capture_reg_a;
      logic [15:0] reload_capture_reg_b;
      // Phase of the PWM reload sequence
      logic next_from_b;
      logic pwm_started;
      logic pin_a_level;
      logic pin_a_oe_n;
      logic irq_a;
      logic irq_b;
   } mtec_st_t;

   mtec_st_t q, d;

   logic tick;
   logic a_rise, a_fall, b_rise, b_fall;
   logic [2:0] mode;
   logic run_or_underflow_bit, pending_flag_a, pending_flag_b;
   logic irq_enable_a, irq_enable_b;
   logic is_pwm, is_evt, is_cap;
   logic cnt_ev, uflow, trig_a, trig_b;
   logic [15:0] cnt_next;
   logic wr_ctrl, wr_hs;
   logic wr_cnt;
   logic [7:0] wval;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // Tick phase runs free; a speed change may shorten one period
   mtec_tick u_tick (
      .clk(clk),
      .reset(reset),
      .fast(q.high_speed_select),
      .tick(tick)
   );

   mtec_sync u_sync_a (
      .clk(clk),
      .reset(reset),
      .din(pins_in.pin_a),
      .dout(),
      .rise(a_rise),
      .fall(a_fall)
   );

   // Only the edges of pin B matter
   mtec_sync u_sync_b (
      .clk(clk),
      .reset(reset),
      .din(pins_in.pin_b),
      .dout(),
      .rise(b_rise),
      .fall(b_fall)
   );

   // ---------------------------------------------------------------
   // Mode decode and count events
   // ---------------------------------------------------------------
   always_comb begin
      mode = q.ctrl[MTEC_BIT_MODE_HI:MTEC_BIT_MODE_LO];
      run_or_underflow_bit = q.ctrl[MTEC_BIT_RUN];
      pending_flag_a = q.ctrl[MTEC_BIT_PNDA];
      pending_flag_b = q.ctrl[MTEC_BIT_PNDB];
      irq_enable_a = q.ctrl[MTEC_BIT_ENA];
      irq_enable_b = q.ctrl[MTEC_BIT_ENB];
      is_pwm = (mode == MTEC_M_PWM_NT) || (mode == MTEC_M_PWM_TG);
      is_evt = (mode == MTEC_M_EVT_POS) || (mode == MTEC_M_EVT_NEG);
      // Every code with the mid bit set is a capture mode
      is_cap = mode[1];
      // Pin A edge polarity per mode; bit 0 low = rising
      trig_a = mode[0] ? a_fall : a_rise;
      // Pin B polarity in capture is the high mode bit
      trig_b = (is_cap && mode[2]) ? b_fall : b_rise;
      cnt_ev = 1'b0;
      if (is_evt) begin
         cnt_ev = run_or_underflow_bit & trig_a;
      end else if (is_cap) begin
         cnt_ev = tick;
      end else if (is_pwm) begin
         cnt_ev = run_or_underflow_bit & tick;
      end
      cnt_next = q.count - 16'h0001;
      uflow = cnt_ev && (q.count == 16'h0000);
   end

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      d = q;
      wval = 8'h00;
      wr_ctrl = 1'b0;
      wr_hs = 1'b0;
      wr_cnt = 1'b0;

      // Bus: one wait cycle, then acknowledge
      unique case (q.bus)
         MTEC_BUS_IDLE: begin
            if (av_req.read || av_req.write) begin
               d.bus = MTEC_BUS_ACK;
               d.rdata = 32'h0000_0000;
               if (av_req.address[3:2] == MTEC_IDX_HI) begin
                  d.rdata = {31'h0, q.high_speed_select};
               end else if (av_req.address == MTEC_OFS_CTRL) begin
                  d.rdata = {24'h0, q.ctrl};
               end else if (av_req.address == MTEC_OFS_COUNT) begin
                  d.rdata = {16'h0, q.count};
               end else begin
                  // Both companions in one word; read has no side effect
                  d.rdata = {q.reload_capture_reg_b,
                             q.reload_capture_reg_a};
               end
            end
         end
         MTEC_BUS_ACK: begin
            d.bus = MTEC_BUS_IDLE;
            if (av_req.write) begin
               wval = av_req.writedata[7:0];
               unique case (av_req.address)
                  MTEC_OFS_CTRL: wr_ctrl = av_req.byteenable[0];
                  MTEC_OFS_SPEED: wr_hs = av_req.byteenable[0];
                  MTEC_OFS_COUNT: begin
                     wr_cnt = 1'b1;
                     if (av_req.byteenable[0]) begin
                        d.count[7:0] = av_req.writedata[7:0];
                     end
                     if (av_req.byteenable[1]) begin
                        d.count[15:8] = av_req.writedata[15:8];
                     end
                  end
                  default: begin
                     if (av_req.byteenable[0]) begin
                        d.reload_capture_reg_a[7:0] = av_req.writedata[7:0];
                     end
                     if (av_req.byteenable[1]) begin
                        d.reload_capture_reg_a[15:8] =
                           av_req.writedata[15:8];
                     end
                     if (av_req.byteenable[2]) begin
                        d.reload_capture_reg_b[7:0] =
                           av_req.writedata[23:16];
                     end
                     if (av_req.byteenable[3]) begin
                        d.reload_capture_reg_b[15:8] =
                           av_req.writedata[31:24];
                     end
                  end
               endcase
            end
         end
      endcase

      // Waitrequest comes straight from a flop
      d.waitreq = (d.bus == MTEC_BUS_IDLE);

      // Control writes are safe at any speed in any mode
      if (wr_ctrl) begin
         d.ctrl = wval;
      end
      if (wr_hs) begin
         d.high_speed_select = wval[MTEC_BIT_HS];
      end
      if (wr_ctrl && mode != wval[MTEC_BIT_MODE_HI:MTEC_BIT_MODE_LO]) begin
         d.pwm_started = 1'b0;
         d.next_from_b = 1'b0;
      end

      // Counting; flag sets by hardware win over software writes
      // A count write is kept if a count step falls with it, unless that step is a PWM underflow reload;
      // Without this a running capture timer drops the write
      if (cnt_ev && !wr_cnt) begin
         d.count = cnt_next;
      end
      if (is_pwm && uflow) begin
         // First reload from A, then alternate starting with B
         if (!q.pwm_started || !q.next_from_b) begin
            d.count = q.reload_capture_reg_a;
            d.ctrl[MTEC_BIT_PNDA] = 1'b1;
            d.next_from_b = 1'b1;
         end else begin
            d.count = q.reload_capture_reg_b;
            d.ctrl[MTEC_BIT_PNDB] = 1'b1;
            d.next_from_b = 1'b0;
         end
         d.pwm_started = 1'b1;
         if (mode == MTEC_M_PWM_TG) begin
            d.pin_a_level = ~q.pin_a_level;
         end
      end
      if (is_evt) begin
         if (uflow) begin
            d.ctrl[MTEC_BIT_PNDA] = 1'b1;
         end
         if (b_rise) begin
            d.ctrl[MTEC_BIT_PNDB] = 1'b1;
         end
      end
      if (is_cap) begin
         // Captures take the count seen before this cycle's step
         if (trig_a) begin
            d.reload_capture_reg_a = q.count;
            d.ctrl[MTEC_BIT_PNDA] = 1'b1;
         end
         if (trig_b) begin
            d.reload_capture_reg_b = q.count;
            d.ctrl[MTEC_BIT_PNDB] = 1'b1;
         end
         if (uflow) begin
            d.ctrl[MTEC_BIT_RUN] = 1'b1;
         end
      end

      // Pin A drives only in PWM modes
      d.pin_a_oe_n = ~is_pwm;

      // Requests gated by enables; underflow also raises A in capture
      // Taken from the settled flags, so a request trails its flag
      d.irq_a = irq_enable_a & (pending_flag_a |
                (is_cap & run_or_underflow_bit));
      d.irq_b = irq_enable_b & pending_flag_b;
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         q <= '0;
         q.bus <= MTEC_BUS_IDLE;
         q.waitreq <= 1'b1;
         q.ctrl <= MTEC_CTRL_RST;
         q.count <= MTEC_WORD_RST;
         q.reload_capture_reg_a <= MTEC_WORD_RST;
         q.reload_capture_reg_b <= MTEC_WORD_RST;
         q.pin_a_oe_n <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign av_rsp.readdata = q.rdata;
   assign av_rsp.waitrequest = q.waitreq;
   assign event_or_capture_pin_a_out = q.pin_a_level;
   assign event_or_capture_pin_a_oe_n = q.pin_a_oe_n;
   assign irq_a = q.irq_a;
   assign irq_b = q.irq_b;
endmodule
`default_nettype wire

// ### verification/mtec_pin_model.sv
`timescale 1ns/1ns
`default_nettype none
module mtec_pin_model (
   // Clock
   input wire logic clk,
   // Pin levels towards the timer
   output var mtec_pkg::mtec_pins_t pins
);
   import mtec_pkg::*;
   initial pins = '0;
   // -------------------------------------------------------
   // Pin stimulus
   // -------------------------------------------------------
   // Held past a slow tick so a synchroniser cannot miss it
   task automatic pulse(input logic [1:0] m);
      @(posedge clk);
      pins <= pins ^ m;
      repeat (60) @(posedge clk);
      pins <= pins ^ m;
      repeat (60) @(posedge clk);
   endtask
   task automatic set(input logic [1:0] l);
      @(posedge clk);
      pins <= l;
      repeat (8) @(posedge clk);
   endtask
endmodule
`default_nettype wire

// ### verification/mtec_timer_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module mtec_timer_monitor (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Register bus
   input wire mtec_pkg::mtec_avreq_t av_req,
   input wire mtec_pkg::mtec_avrsp_t av_rsp,
   // Pins and requests
   input wire mtec_pkg::mtec_pins_t pins_in,
   input wire logic event_or_capture_pin_a_out,
   input wire logic event_or_capture_pin_a_oe_n,
   input wire logic irq_a,
   input wire logic irq_b
);
   import mtec_pkg::*;
   logic [2:0] mode_q;
   logic [1:0] age_q;
   logic ena_q;
   logic enb_q;
   logic wr_c;
   logic calm;
   logic req;
   assign req = av_req.read || av_req.write;
   assign wr_c = av_req.write && !av_rsp.waitrequest && av_req.address == 4'h0;
   assign calm = age_q == 2'h3;
   // -------------------------------------------------------
   // Shadow of the software control fields
   // -------------------------------------------------------
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         mode_q <= 3'h0;
         age_q <= 2'h0;
         ena_q <= 1'h0;
         enb_q <= 1'h0;
      end else if (wr_c) begin
         mode_q <= av_req.writedata[3:1];
         age_q <= 2'h0;
         ena_q <= av_req.writedata[5];
         enb_q <= av_req.writedata[7];
      end else if (!calm) begin
         age_q <= age_q + 2'h1;
      end
   end
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (reset);
   AST_ONE_WAIT: assert property (
      req && av_rsp.waitrequest |=> !av_rsp.waitrequest)
      else $error("no ack after one wait");
   AST_ACK_PULSE: assert property (
      !av_rsp.waitrequest |=> av_rsp.waitrequest)
      else $error("ack too long");
   AST_IDLE_WAIT: assert property (!req |-> av_rsp.waitrequest)
      else $error("ack without request");
   AST_MASK_A: assert property (!ena_q && !$past(ena_q) |-> !irq_a)
      else $error("irq_a while disabled");
   AST_MASK_B: assert property (!enb_q && !$past(enb_q) |-> !irq_b)
      else $error("irq_b while disabled");
   AST_PIN_FREE: assert property (
      calm && (!mode_q[2] || mode_q[1]) |-> event_or_capture_pin_a_oe_n)
      else $error("pin a driven outside pwm");
   AST_PIN_DRIVE: assert property (
      calm && mode_q == MTEC_M_PWM_TG |-> !event_or_capture_pin_a_oe_n)
      else $error("pin a not driven in toggle pwm");
   AST_NO_TOGGLE: assert property (
      calm && mode_q == MTEC_M_PWM_NT |-> $stable(event_or_capture_pin_a_out))
      else $error("pin a toggles in no-toggle pwm");
   AST_EDGE_B: assert property (
      mode_q[2:1] == 2'h0 && enb_q && $rose(pins_in.pin_b) |-> ##[2:8] irq_b)
      else $error("pin b edge gave no irq_b");
   cover property ($rose(irq_a));
   cover property ($rose(irq_b));
   cover property ($changed(event_or_capture_pin_a_out));
endmodule
bind mtec_timer mtec_timer_monitor mtec_timer_monitor_inst (.clk(clk),
   .reset(reset), .av_req(av_req), .av_rsp(av_rsp), .pins_in(pins_in),
   .event_or_capture_pin_a_out(event_or_capture_pin_a_out),
   .event_or_capture_pin_a_oe_n(event_or_capture_pin_a_oe_n),
   .irq_a(irq_a), .irq_b(irq_b));
`default_nettype wire

// ### verification/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import mtec_pkg::*;
   logic clk;
   logic reset;
   mtec_avreq_t av_req;
   mtec_avrsp_t av_rsp;
   mtec_pins_t pins;
   logic pa_out;
   logic pa_oe_n;
   logic irq_a;
   logic irq_b;
   int n_errors = 0;
   int comparisons = 0;
   int cyc = 0;
   int last_tg = -1;
   int seed = 32'hDEB66921;
   int tk;
   int g;
   logic last_pin = 1'h0;
   logic [31:0] rdata;
   logic [31:0] v;
   logic [15:0] c1;
   logic [15:0] c2;
   logic [31:0] lo_q[$];
   logic [31:0] hi_q[$];
   int gap_q[$];
   logic [2:0] cm[4] = '{3'h2, 3'h6, 3'h3, 3'h7};
   logic [2:0] pm[3] = '{3'h5, 3'h5, 3'h4};
   mtec_timer mtec_timer_inst (.clk(clk), .reset(reset), .av_req(av_req),
      .av_rsp(av_rsp), .pins_in(pins), .event_or_capture_pin_a_out(pa_out),
      .event_or_capture_pin_a_oe_n(pa_oe_n), .irq_a(irq_a), .irq_b(irq_b));
   mtec_pin_model mtec_pin_model_inst (.clk(clk), .pins(pins));
   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end
   // -------------------------------------------------------
   // Compare, bus and report tasks
   // -------------------------------------------------------
   task automatic check(input logic [31:0] got, lo, hi);
      comparisons++;
      if ((got >= lo && got <= hi) !== 1'h1) begin
         n_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
      end
   endtask
   task automatic check_bit(input logic got, exp);
      check({31'h0, got}, {31'h0, exp}, {31'h0, exp});
   endtask
   task automatic bus(input logic w, input logic [3:0] a,
                      input logic [31:0] d, lo, hi);
      int n;
      n = 0;
      @(posedge clk);
      if (!w) begin
         lo_q.push_back(lo);
         hi_q.push_back(hi);
      end
      av_req.address <= a;
      av_req.write <= w;
      av_req.read <= !w;
      av_req.writedata <= d;
      do begin
         @(posedge clk);
         n++;
      end while (av_rsp.waitrequest !== 1'h0 && n < 20);
      if (n >= 20) begin
         n_errors++;
         give_verdict();
      end
      rdata = av_rsp.readdata;
      av_req.read <= 1'h0;
      av_req.write <= 1'h0;
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      bus(1'h1, a, d, 32'h0, 32'h0);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] lo, hi);
      bus(1'h0, a, 32'h0, lo, hi);
   endtask
   task automatic done(input string s);
      $display("test %s finished", s);
   endtask
   task automatic give_verdict;
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // -------------------------------------------------------
   // Result watcher: read data and pin a toggle spacing
   // -------------------------------------------------------
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc > 40000) begin
         n_errors++;
         give_verdict();
      end
      if (av_req.read === 1'h1 && av_rsp.waitrequest === 1'h0)
         check(av_rsp.readdata, lo_q.pop_front(), hi_q.pop_front());
      if (pa_out !== last_pin) begin
         if (last_tg >= 0) begin
            g = gap_q.pop_front();
            check(32'(cyc - last_tg), 32'(g), 32'(g));
         end
         last_tg = gap_q.size() > 0 ? cyc : -1;
         last_pin = pa_out;
      end
   end
   initial begin
      reset = 1'h1;
      av_req = '0;
      av_req.byteenable = 4'hF;
      repeat (12) @(posedge clk);
      reset <= 1'h0;
      rd(4'h0, 32'h0, 32'h0);
      rd(4'h4, 32'h0, 32'h0);
      rd(4'hC, 32'h0, 32'h0);
      for (int i = 0; i < 4; i++) begin
         v = $random(seed);
         wr(4'h8, v);
         rd(4'h8, {16'h0, v[15:0]}, {16'h0, v[15:0]});
         wr(4'hC, v);
         rd(4'hC, v, v);
      end
      wr(4'h4, 32'h1);
      rd(4'h4, 32'h1, 32'h1);
      done("registers");
      for (int m = 0; m < 2; m++) begin
         wr(4'h0, 32'h0);
         wr(4'h8, 32'h1);
         wr(4'h0, 32'hA1 | (m << 1));
         repeat (2) mtec_pin_model_inst.pulse(2'h2);
         mtec_pin_model_inst.pulse(2'h1);
         rd(4'h0, 32'hF1 | (m << 1), 32'hF1 | (m << 1));
         rd(4'h8, 32'hFFFF, 32'hFFFF);
         check_bit(irq_b, 1'h1);
         wr(4'h0, 32'h51 | (m << 1));
         repeat (4) @(posedge clk);
         check_bit(irq_a, 1'h0);
      end
      done("event");
      foreach (cm[i]) begin
         mtec_pin_model_inst.set({cm[i][0], cm[i][2]});
         wr(4'h8, 32'hF000);
         wr(4'h0, 32'hA0 | (cm[i] << 1));
         rd(4'h8, 32'h0, 32'hFFFF);
         c1 = rdata[15:0];
         mtec_pin_model_inst.set({!cm[i][0], !cm[i][2]});
         repeat (12) @(posedge clk);
         rd(4'h8, 32'h0, 32'hFFFF);
         c2 = rdata[15:0];
         // Reverse edge must leave the captures alone
         mtec_pin_model_inst.set({cm[i][0], cm[i][2]});
         rd(4'hC, {c2, c2}, {c1, c1});
         rd(4'h0, 32'hF0 | (cm[i] << 1), 32'hF0 | (cm[i] << 1));
      end
      wr(4'h0, 32'h24);
      wr(4'h8, 32'h2);
      // Fast ticks take the count from 2 through 0 to all ones; 200 cycles give about 40 ticks
      repeat (200) @(posedge clk);
      rd(4'h0, 32'h25, 32'h25);
      check_bit(irq_a, 1'h1);
      rd(4'h8, 32'hFF00, 32'hFFFF);
      done("capture");
      foreach (pm[k]) begin
         tk = k == 1 ? MTEC_TC_CYC : MTEC_MCLK_CYC;
         wr(4'h4, {31'h0, k != 1});
         wr(4'h0, 32'h0);
         wr(4'hC, {16'h6, 16'h3});
         wr(4'h8, 32'h0);
         if (pm[k] == MTEC_M_PWM_TG)
            gap_q = '{4 * tk, 7 * tk, 4 * tk, 7 * tk};
         wr(4'h0, 32'hA1 | (pm[k] << 1));
         repeat (40 * tk) @(posedge clk);
         rd(4'h0, 32'hF1 | (pm[k] << 1), 32'hF1 | (pm[k] << 1));
         check(32'(gap_q.size()), 32'h0, 32'h0);
      end
      wr(4'h0, 32'h0);
      done("pwm");
      give_verdict();
   end
endmodule
`default_nettype wire
